//--- dv/adc_ctrl_monitor.sv
// Port checker for the converter control block
`timescale 1ns/10ps
module adc_ctrl_monitor
	import adc_ctrl_pkg::*;
#(
	parameter int RELOCK_CYCLES = RELOCK_CYC
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                srst_i,
	// Watched ports
	input  wire logic                sleep_request_i,
	input  wire logic                output_float_request_i,
	input  wire logic                sample_stb_o,
	input  wire logic                stab_active_o,
	input  wire logic                powered_down_o,
	input  wire logic                reference_on_o,
	input  wire logic [SAMPLE_W-1:0] data_oe_o,
	input  wire logic                over_o,
	input  wire logic                over_oe_o,
	input  wire logic                forwarded_data_clock_oe_o
);
	int low_cnt_ff;
	always_ff @(posedge clk_i) begin
		low_cnt_ff <= (srst_i || stab_active_o) ? 0 : low_cnt_ff + 1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_down_floats: assert property (
		powered_down_o |-> data_oe_o == '0 && !over_oe_o
			&& !forwarded_data_clock_oe_o)
		else $error("drivers on in power-down");
	a_ref_only_down: assert property (
		!reference_on_o |-> powered_down_o)
		else $error("reference off outside power-down");
	a_pin_sleeps: assert property (
		sleep_request_i [*5] |-> ##[0:3] powered_down_o)
		else $error("sleep pin ignored");
	a_pin_floats: assert property (
		output_float_request_i [*5] |-> ##[0:3] (data_oe_o == '0 && !over_oe_o))
		else $error("float pin ignored");
	a_oe_whole: assert property (
		data_oe_o == '0 || data_oe_o == '1)
		else $error("partial data enable");
	a_stb_period: assert property (
		sample_stb_o && !powered_down_o |-> ##[1:16]
			(sample_stb_o || powered_down_o))
		else $error("sample strobe lost");
	a_stab_fast: assert property (
		sample_stb_o && stab_active_o |-> ##[1:3]
			(sample_stb_o || !stab_active_o))
		else $error("stabilizer on at slow rate");
	a_relock_wait: assert property (
		$rose(stab_active_o) |-> low_cnt_ff >= RELOCK_CYCLES - 1)
		else $error("relock interval too short");
	a_stab_default: assert property (
		$fell(srst_i) |-> stab_active_o && reference_on_o)
		else $error("stabilizer off after reset");
	c_sleep: cover property (powered_down_o);
	c_relock: cover property ($rose(stab_active_o));
	c_over: cover property (over_o);
endmodule : adc_ctrl_monitor

//--- dv/capture_model.sv
// Receiver capture registers clocked by the forwarded data clock
`timescale 1ns/10ps
module capture_model
	import adc_ctrl_pkg::*;
(
	// Lines from the converter
	input  wire logic                fdc_i,
	input  wire logic [SAMPLE_W-1:0] data_i,
	input  wire logic [SAMPLE_W-1:0] oe_i,
	// Captured words
	output logic      [SAMPLE_W-1:0] rise_o,
	output logic      [SAMPLE_W-1:0] fall_o
);
	logic [SAMPLE_W-1:0] last_ff = '0;
	// Undriven lines show the inverse of their last level
	wire  [SAMPLE_W-1:0] line_w  = (data_i & oe_i) | (~last_ff & ~oe_i);
	always @(posedge fdc_i) begin
		rise_o  <= line_w;
		last_ff <= line_w;
	end
	always @(negedge fdc_i) begin
		fall_o <= line_w;
	end
endmodule : capture_model

//--- dv/test_adc_ctrl.sv
// Testbench for the converter control block
`timescale 1ns/10ps
module test_adc_ctrl
	import adc_ctrl_pkg::*;
;
	localparam int RELOCK = 8;
	localparam logic [14:0] VALS [6] = '{15'h0000, 15'h1fff, 15'h6000,
		15'h2000, 15'h5fff, 15'h0064};
	logic clk_i, srst_i, reg_wr_i, reg_rd_i, sleep_request_i;
	logic output_float_request_i, align_strobe_i;
	logic [3:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o;
	logic [SAMPLE_W:0] raw_a_i, raw_b_i;
	logic sample_clk_o, sample_stb_o, stab_active_o, powered_down_o;
	logic reference_on_o, over_o, over_oe_o;
	logic forwarded_data_clock_o, forwarded_data_clock_oe_o;
	logic [SAMPLE_W-1:0] data_o, data_oe_o, cap_rise, cap_fall;
	int fails, samples_checked, cycles;
	adc_ctrl #(.RELOCK_CYCLES(RELOCK)) dut_u (.clk_i, .srst_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sleep_request_i,
		.output_float_request_i, .align_strobe_i, .raw_a_i, .raw_b_i,
		.sample_clk_o, .sample_stb_o, .stab_active_o, .powered_down_o,
		.reference_on_o, .data_o, .data_oe_o, .over_o, .over_oe_o,
		.forwarded_data_clock_o, .forwarded_data_clock_oe_o);
	capture_model cap_u (.fdc_i(forwarded_data_clock_o), .data_i(data_o),
		.oe_i(data_oe_o), .rise_o(cap_rise), .fall_o(cap_fall));
	always #4 clk_i = ~clk_i;
	function automatic logic [14:0] exp_code(input logic signed [14:0] v,
		input logic [1:0] f);
		logic [13:0] o;
		logic        ovr;
		ovr = (v > 15'sh1fff) || (v < -15'sh2000);
		o = (v > 15'sh1fff) ? 14'h3fff : (v < -15'sh2000) ? 14'h0000
			: v[13:0] ^ 14'h2000;
		if (f == 2'b01) return {ovr, o ^ 14'h2000};
		if (f == 2'b10) return {ovr, o ^ (o >> 1)};
		return {ovr, o};
	endfunction : exp_code
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task automatic stb(output int n);
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (sample_stb_o !== 1'b1 && n < 100);
	endtask : stb
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		cyc(1);
		reg_rd_i <= 1'b0;
		d = reg_rdata_o;
	endtask : rd
	task automatic t_reset;
		logic [7:0] d;
		check(16'({stab_active_o, reference_on_o}), 16'h0003);
		rd(ADDR_CLK_CTRL, d);
		check(16'(d), 16'(CLK_CTRL_RST));
		rd(ADDR_OUT_CTRL, d);
		check(16'(d), 16'(OUT_CTRL_RST));
		rd(ADDR_PWR_CTRL, d);
		check(16'(d), 16'(PWR_CTRL_RST));
		wr(4'hf, 8'hff);
		rd(4'hf, d);
		check(16'(d), 16'h0000);
	endtask : t_reset
	task automatic t_ratio;
		int n;
		for (int r = 1; r <= DIV_MAX; r++) begin
			wr(ADDR_CLK_CTRL, 8'(r - 1) | 8'h08);
			cyc(3);
			if (r == 2 || r == 3) check(16'(stab_active_o), 16'h0000);
			cyc(RELOCK + 20);
			stb(n);
			stb(n);
			check(16'(n), 16'(r));
			check(16'(stab_active_o), 16'(r <= 3));
			n = 0;
			repeat (r) begin
				cyc(1);
				if (sample_clk_o === 1'b1) n++;
			end
			check(16'(n), 16'((r >= 2 && r <= 3) ? r / 2 : 1));
		end
	endtask : t_ratio
	task automatic pulse(input int g, output int d);
		cyc(g);
		@(posedge clk_i) align_strobe_i <= 1'b1;
		cyc(6);
		@(posedge clk_i) align_strobe_i <= 1'b0;
		cyc(3);
		stb(d);
	endtask : pulse
	task automatic t_align;
		int d1, d2;
		logic [7:0] s;
		wr(ADDR_CLK_CTRL, 8'h14);
		pulse(0, d1);
		pulse(2, d2);
		check(16'(d1), 16'(d2));
		wr(ADDR_CLK_CTRL, 8'h34);
		rd(ADDR_STATUS, s);
		check(16'(s[1]), 16'h0001);
		pulse(1, d1);
		rd(ADDR_STATUS, s);
		check(16'(s[1]), 16'h0000);
	endtask : t_align
	task automatic t_format;
		logic [14:0] e;
		wr(ADDR_CLK_CTRL, 8'h09);
		for (int f = 0; f < 3; f++) begin
			wr(ADDR_OUT_CTRL, 8'(f) | 8'h08);
			for (int i = 0; i < 6; i++) begin
				@(posedge clk_i) raw_a_i <= VALS[i];
				raw_b_i <= ~VALS[i];
				cyc(40);
				e = exp_code(VALS[i], 2'(f));
				check(16'({over_o, data_o}), 16'(e));
				check(16'(cap_rise), 16'(e[13:0]));
				check(16'(cap_fall), 16'(e[13:0]));
			end
		end
		wr(ADDR_OUT_CTRL, 8'h05);
		cyc(40);
		e = exp_code(~VALS[5], 2'b01);
		check(16'({over_o, data_o}), 16'(e));
		check(16'(data_oe_o), 16'h3fff);
		wr(ADDR_OUT_CTRL, 8'h0d);
		cyc(8);
		check(16'(data_oe_o), 16'h0000);
	endtask : t_format
	task automatic t_latency;
		int n;
		wr(ADDR_OUT_CTRL, 8'h09);
		@(posedge clk_i) raw_a_i <= 15'h0000;
		cyc(40);
		@(posedge clk_i) raw_a_i <= 15'h2000;
		n = 0;
		for (int k = 0; k < 60 && over_o !== 1'b1; k++) begin
			cyc(1);
			if (sample_stb_o === 1'b1) n++;
		end
		check(16'(n >= PIPE_LATENCY && n <= PIPE_LATENCY + 1), 16'h0001);
		check(16'(data_o), 16'h1fff);
		wr(ADDR_OUT_CTRL, 8'h01);
	endtask : t_latency
	task automatic t_power;
		logic [7:0] s;
		@(posedge clk_i) sleep_request_i <= 1'b1;
		cyc(8);
		check(16'({powered_down_o, reference_on_o, data_oe_o}), 16'h8000);
		@(posedge clk_i) sleep_request_i <= 1'b0;
		cyc(8);
		check(16'({powered_down_o, data_oe_o}), 16'h3fff);
		wr(ADDR_PWR_CTRL, 8'h01);
		rd(ADDR_STATUS, s);
		check(16'({powered_down_o, s[0]}), 16'h0003);
		wr(ADDR_PWR_CTRL, 8'h02);
		cyc(2);
		check(16'(reference_on_o), 16'h0001);
		wr(ADDR_PWR_CTRL, 8'h00);
		@(posedge clk_i) output_float_request_i <= 1'b1;
		cyc(8);
		check(16'({over_oe_o, data_oe_o}), 16'h0000);
		@(posedge clk_i) output_float_request_i <= 1'b0;
		cyc(8);
		check(16'(data_oe_o), 16'h3fff);
	endtask : t_power
	task automatic final_report;
		$display("checked=%0d failed=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : final_report
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		{clk_i, reg_wr_i, reg_rd_i, sleep_request_i, align_strobe_i} = '0;
		{output_float_request_i, reg_addr_i, reg_wdata_i} = '0;
		{raw_a_i, raw_b_i, fails, samples_checked, cycles} = '0;
		srst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		cyc(1);
		t_reset();
		t_ratio();
		t_align();
		t_format();
		t_latency();
		t_power();
		final_report();
	end
endmodule : test_adc_ctrl
bind adc_ctrl adc_ctrl_monitor #(.RELOCK_CYCLES(RELOCK_CYCLES)) mon_u (
	.clk_i, .srst_i, .sleep_request_i, .output_float_request_i, .sample_stb_o,
	.stab_active_o, .powered_down_o, .reference_on_o, .data_oe_o, .over_o,
	.over_oe_o, .forwarded_data_clock_oe_o);

//--- hdl/adc_ctrl.sv
// Module: clock divider, stabilizer, power and output control
//
// Function
// [RULE1] Sample clock is the input clock divided by a ratio of one to eight.
// [RULE2] Duty stabilizer is enabled from reset without any write.
// [RULE3] Two bits choose realign on every strobe or only first after write.
// [RULE4] An accepted strobe returns the divider to its initial count.
// [RULE5] Stabilizer makes the falling edge land at half period; rise untouched.
// [RULE6] Stabilizer loop counts as not working below the minimum frequency.
// [RULE7] After a rate change the loop is bypassed through a relock interval.
// [RULE8] Sleep bit or sleep pin high powers down and floats the drivers.
// [RULE9] Sleep pin low returns the converter to normal operation.
// [RULE10] Standby keeps the reference powered for a faster wake-up.
// [RULE11] Output code format is offset binary, two's complement or Gray.
// [RULE12] Float pin low enables drivers, high floats them; slow control only.
// [RULE13] A bit per channel floats that channel's data outputs.
// [RULE14] With one channel off, the other appears on both clock halves.
// [RULE15] Samples appear a fixed ten sample clocks after capture.
// [RULE16] Overrange flag is delayed by the same latency as its sample.
// [RULE17] Two's complement is default; zero maps to midscale code.
// [RULE18] Beyond full scale saturates at extreme code with the flag high.
// [RULE19] A forwarded data clock goes out beside the data.
// [RULE20] Each sample is taken on the rising sample clock edge.
// [RULE21] Alignment strobe is synchronised before acting on the divider.
// [RULE22] Effective sleep and driver disable are ORs of pin and bits.
// [RULE23] Channel one is valid at one clock edge, channel two at the other.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/10ps
module adc_ctrl
	import adc_ctrl_pkg::*;
#(
	parameter int RELOCK_CYCLES = RELOCK_CYC
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                srst_i,
	// Register port
	input  wire logic [3:0]          reg_addr_i,
	input  wire logic [7:0]          reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output logic      [7:0]          reg_rdata_o,
	// Pins
	input  wire logic                sleep_request_i,
	input  wire logic                output_float_request_i,
	input  wire logic                align_strobe_i,
	// Quantizer results, signed, one per channel
	input  wire logic [SAMPLE_W:0]   raw_a_i,
	input  wire logic [SAMPLE_W:0]   raw_b_i,
	// Sample clock and power status
	output logic                     sample_clk_o,
	output logic                     sample_stb_o,
	output logic                     stab_active_o,
	output logic                     powered_down_o,
	output logic                     reference_on_o,
	// Output port
	output logic      [SAMPLE_W-1:0] data_o,
	output logic      [SAMPLE_W-1:0] data_oe_o,
	output logic                     over_o,
	output logic                     over_oe_o,
	output logic                     forwarded_data_clock_o,
	output logic                     forwarded_data_clock_oe_o
);

	localparam logic [SAMPLE_W:0] POS_FS = (SAMPLE_W+1)'(2**(SAMPLE_W-1) - 1);
	localparam logic [SAMPLE_W:0] NEG_FS = ~POS_FS;
	localparam logic [SAMPLE_W-1:0] MSB_BIT =
		SAMPLE_W'(2**(SAMPLE_W-1));

	// Registers
	logic [7:0]       clk_ctrl_ff;
	logic [7:0]       pwr_ctrl_ff;
	logic [7:0]       out_ctrl_ff;
	logic             align_armed_ff;
	logic [2:0]       sleep_sync_ff;
	logic [2:0]       float_sync_ff;
	logic [2:0]       align_sync_ff;
	logic             sleep_pin_ff;
	logic             float_pin_ff;
	logic             align_lvl_ff;
	logic [DIV_W-1:0] div_cnt_ff;
	logic             sclk_ff;
	logic [DIV_W-1:0] ratio_ff;
	logic [15:0]      relock_ff;
	logic             half_ff;
	logic [SAMPLE_W-1:0] data_ff;
	logic             over_ff;
	logic             dclk_ff;
	logic             rd_valid_ff;
	logic [7:0]       rdata_ff;
	pwr_state_t       pwr_ff;
	pwr_state_t       nxt_pwr;

	// Decode
	wire wr_clk  = reg_wr_i && (reg_addr_i == ADDR_CLK_CTRL);
	wire wr_pwr  = reg_wr_i && (reg_addr_i == ADDR_PWR_CTRL);
	wire wr_out  = reg_wr_i && (reg_addr_i == ADDR_OUT_CTRL);
	wire [DIV_W-1:0] ratio_m1 = clk_ctrl_ff[CLK_RATIO_LSB +: DIV_W];
	wire stab_en  = clk_ctrl_ff[CLK_STAB_EN];
	wire align_en = clk_ctrl_ff[CLK_ALIGN_EN];
	wire align_once = clk_ctrl_ff[CLK_ALIGN_ONCE];
	fmt_t fmt;
	assign fmt = fmt_t'(out_ctrl_ff[OUT_FMT_LSB +: 2]);

	// Register file
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			clk_ctrl_ff <= CLK_CTRL_RST; // [RULE2]
			pwr_ctrl_ff <= PWR_CTRL_RST;
			out_ctrl_ff <= OUT_CTRL_RST; // [RULE17]
		end else begin
			if (wr_clk) clk_ctrl_ff <= reg_wdata_i;
			if (wr_pwr) pwr_ctrl_ff <= reg_wdata_i;
			if (wr_out) out_ctrl_ff <= reg_wdata_i;
		end
	end

	// Pin synchronisers; a change counts once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sleep_sync_ff <= 3'h0;
			float_sync_ff <= 3'h0;
			align_sync_ff <= 3'h0;
			sleep_pin_ff  <= 1'b0;
			float_pin_ff  <= 1'b0;
			align_lvl_ff  <= 1'b0;
		end else begin
			sleep_sync_ff <= {sleep_sync_ff[1:0], sleep_request_i};
			float_sync_ff <= {float_sync_ff[1:0], output_float_request_i};
			align_sync_ff <= {align_sync_ff[1:0], align_strobe_i}; // [RULE21]
			if (sleep_sync_ff[1] == sleep_sync_ff[2])
				sleep_pin_ff <= sleep_sync_ff[2];
			if (float_sync_ff[1] == float_sync_ff[2])
				float_pin_ff <= float_sync_ff[2];
			if (align_sync_ff[1] == align_sync_ff[2])
				align_lvl_ff <= align_sync_ff[2];
		end
	end

	wire align_rise = (align_sync_ff[1] == align_sync_ff[2]) &&
	                  align_sync_ff[2] && !align_lvl_ff;
	// Accepted strobe: every one, or only the first after a write
	wire align_take = align_rise && align_en &&
	                  (!align_once || align_armed_ff); // [RULE3]

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			align_armed_ff <= 1'b0;
		end else if (wr_clk) begin
			align_armed_ff <= 1'b1; // [RULE3]
		end else if (align_take) begin
			align_armed_ff <= 1'b0;
		end
	end

	// Power state
	wire sleep_eff = sleep_pin_ff || pwr_ctrl_ff[PWR_SLEEP]; // [RULE22]
	always_comb begin
		case (pwr_ff)
			PWR_RUN, PWR_STBY, PWR_DOWN: begin
				if (sleep_eff)
					nxt_pwr = PWR_DOWN; // [RULE8]
				else if (pwr_ctrl_ff[PWR_STANDBY])
					nxt_pwr = PWR_STBY; // [RULE10]
				else
					nxt_pwr = PWR_RUN; // [RULE9]
			end
			default: nxt_pwr = PWR_RUN;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) pwr_ff <= PWR_RUN;
		else        pwr_ff <= nxt_pwr;
	end

	wire running = (pwr_ff == PWR_RUN);
	assign powered_down_o = (pwr_ff == PWR_DOWN);
	assign reference_on_o = (pwr_ff != PWR_DOWN); // [RULE10]

	// Divider: sample clock rises when the count wraps to its start
	wire div_wrap = (div_cnt_ff == ratio_m1);
	wire ratio_chg = (ratio_ff != ratio_m1);
	always_ff @(posedge clk_i) begin
		if (srst_i || !running) begin
			div_cnt_ff <= '0;
			sclk_ff    <= 1'b0;
		end else if (align_take) begin
			div_cnt_ff <= '0; // [RULE4]
			sclk_ff    <= 1'b0;
		end else begin
			div_cnt_ff <= div_wrap ? '0 : div_cnt_ff + 1'b1; // [RULE1]
			sclk_ff    <= div_wrap;
		end
	end

	// Rising sampling edge
	assign sample_stb_o = sclk_ff; // [RULE20]

	// Half-period mark for the regenerated falling edge
	wire [DIV_W:0] ratio_n = {1'b0, ratio_m1} + 1'b1;
	wire [DIV_W:0] half_pt = ratio_n >> 1;
	wire at_half = ({1'b0, div_cnt_ff} == half_pt);
	// Loop works only while a sample period is short enough
	wire fast_enough = (32'(ratio_n) <= MIN_FREQ_CYC); // [RULE6]

	// Relock interval after any ratio change
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ratio_ff  <= '0;
			relock_ff <= '0;
		end else begin
			ratio_ff <= ratio_m1;
			if (ratio_chg || !running)
				relock_ff <= 16'(RELOCK_CYCLES); // [RULE7]
			else if (relock_ff != 16'h0000)
				relock_ff <= relock_ff - 16'h0001;
		end
	end

	assign stab_active_o = stab_en && fast_enough && running && !ratio_chg &&
	                       (relock_ff == 16'h0000); // [RULE7]

	// Internal clock: with stabilizer, high for half the period
	always_ff @(posedge clk_i) begin
		if (srst_i || !running) begin
			half_ff <= 1'b0;
		end else if (sclk_ff) begin
			half_ff <= 1'b1; // [RULE5]
		end else if (at_half || ratio_n == 4'h1) begin
			half_ff <= 1'b0; // [RULE5]
		end
	end
	// Bypassed: the raw single-cycle pulse sets the high time
	assign sample_clk_o = stab_active_o ? half_ff : sclk_ff; // [RULE5]

	// Formatting: saturate, then map to the chosen code
	function automatic logic [SAMPLE_W:0] sat(input logic [SAMPLE_W:0] v);
		if ($signed(v) > $signed(POS_FS))      sat = POS_FS; // [RULE18]
		else if ($signed(v) < $signed(NEG_FS)) sat = NEG_FS;
		else                                   sat = v;
	endfunction : sat

	function automatic logic [SAMPLE_W-1:0] fmt_code(
		input logic [SAMPLE_W:0] v, input fmt_t f);
		logic [SAMPLE_W-1:0] tc;
		logic [SAMPLE_W-1:0] ob;
		logic [SAMPLE_W:0]   sv;
		sv = sat(v);
		tc = sv[SAMPLE_W-1:0];
		ob = tc ^ MSB_BIT;
		case (f)
			FMT_OFFSET: fmt_code = ob; // [RULE11]
			FMT_GRAY:   fmt_code = ob ^ (ob >> 1);
			default:    fmt_code = tc; // [RULE17]
		endcase
	endfunction : fmt_code

	wire ovr_a = ($signed(raw_a_i) > $signed(POS_FS)) ||
	             ($signed(raw_a_i) < $signed(NEG_FS)); // [RULE18]
	wire ovr_b = ($signed(raw_b_i) > $signed(POS_FS)) ||
	             ($signed(raw_b_i) < $signed(NEG_FS));

	// Pipeline
	sample_if fmt_bus ();
	sample_if pipe_bus ();
	assign fmt_bus.code_a = fmt_code(raw_a_i, fmt);
	assign fmt_bus.code_b = fmt_code(raw_b_i, fmt);
	assign fmt_bus.over_a = ovr_a;
	assign fmt_bus.over_b = ovr_b;
	assign fmt_bus.strobe = sclk_ff;

	sample_pipe #(
		.DEPTH (PIPE_LATENCY)
	) u_pipe (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.adv_i  (sclk_ff), // [RULE15] [RULE16]
		.in_if  (fmt_bus),
		.out_if (pipe_bus)
	);

	// Output drive: channel two on rising half, channel one on falling
	wire float_a = float_pin_ff || out_ctrl_ff[OUT_FLOAT_A]; // [RULE22]
	wire float_b = float_pin_ff || out_ctrl_ff[OUT_FLOAT_B];
	wire drv_on  = !float_pin_ff && (pwr_ff != PWR_DOWN); // [RULE12] [RULE8]
	wire use_b   = (half_ff && !float_b) || float_a; // [RULE14] [RULE23]
	wire any_on  = drv_on && !(float_a && float_b); // [RULE13]

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			data_ff <= '0;
			over_ff <= 1'b0;
			dclk_ff <= 1'b0;
		end else begin
			data_ff <= use_b ? pipe_bus.code_b : pipe_bus.code_a;
			over_ff <= use_b ? pipe_bus.over_b : pipe_bus.over_a;
			dclk_ff <= half_ff; // [RULE19]
		end
	end

	assign data_o    = data_ff;
	assign over_o    = over_ff;
	assign data_oe_o = {SAMPLE_W{any_on}};
	assign over_oe_o = any_on;
	assign forwarded_data_clock_o    = dclk_ff;
	assign forwarded_data_clock_oe_o = drv_on; // [RULE19]

	// Read port
	wire [7:0] status = {5'h00, stab_active_o, align_armed_ff,
	                     powered_down_o};
	wire [7:0] rd_mux =
		(reg_addr_i == ADDR_CLK_CTRL) ? clk_ctrl_ff :
		(reg_addr_i == ADDR_PWR_CTRL) ? pwr_ctrl_ff :
		(reg_addr_i == ADDR_OUT_CTRL) ? out_ctrl_ff :
		(reg_addr_i == ADDR_STATUS)   ? status      : 8'h00;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rd_valid_ff <= 1'b0;
			rdata_ff    <= 8'h00;
		end else begin
			rd_valid_ff <= reg_rd_i;
			rdata_ff    <= reg_rd_i ? rd_mux : 8'h00;
		end
	end
	assign reg_rdata_o = rd_valid_ff ? rdata_ff : 8'h00;

endmodule : adc_ctrl

//--- hdl/adc_ctrl_pkg.sv
// Package: constants and types for the dual converter control block
package adc_ctrl_pkg;

	localparam int SAMPLE_W      = 14;
	localparam int DIV_MAX       = 8;
	localparam int DIV_W         = 3;
	localparam int PIPE_LATENCY  = 10;

	// Clock rate and stabilizer timing
	localparam int CLK_MHZ        = 125;
	localparam int RELOCK_NS      = 1500;
	localparam int RELOCK_CYC     = (RELOCK_NS * CLK_MHZ + 999) / 1000;
	localparam int MIN_FREQ_MHZ   = 40;
	// Greatest sample-clock period, in system cycles, for the loop to work
	localparam int MIN_FREQ_CYC   = CLK_MHZ / MIN_FREQ_MHZ;

	// Register map
	localparam logic [3:0] ADDR_CLK_CTRL  = 4'h0;
	localparam logic [3:0] ADDR_PWR_CTRL  = 4'h1;
	localparam logic [3:0] ADDR_OUT_CTRL  = 4'h2;
	localparam logic [3:0] ADDR_STATUS    = 4'h3;

	// Clock control fields
	localparam int CLK_RATIO_LSB  = 0;
	localparam int CLK_STAB_EN    = 3;
	localparam int CLK_ALIGN_EN   = 4;
	localparam int CLK_ALIGN_ONCE = 5;
	localparam logic [7:0] CLK_CTRL_RST = 8'h08;

	// Power control fields
	localparam int PWR_SLEEP      = 0;
	localparam int PWR_STANDBY    = 1;
	localparam logic [7:0] PWR_CTRL_RST = 8'h00;

	// Output control fields
	localparam int OUT_FMT_LSB    = 0;
	localparam int OUT_FLOAT_A    = 2;
	localparam int OUT_FLOAT_B    = 3;
	localparam logic [7:0] OUT_CTRL_RST = 8'h01;

	typedef enum logic [1:0] {
		FMT_OFFSET = 2'b00,
		FMT_TWOS   = 2'b01,
		FMT_GRAY   = 2'b10
	} fmt_t;

	typedef enum logic [2:0] {
		PWR_RUN   = 3'b001,
		PWR_STBY  = 3'b010,
		PWR_DOWN  = 3'b100
	} pwr_state_t;

endpackage : adc_ctrl_pkg

//--- hdl/sample_if.sv
// Interface: sample stream from formatter to output stage
`timescale 1ns/10ps
interface sample_if;
	import adc_ctrl_pkg::*;
	logic [SAMPLE_W-1:0] code_a;
	logic [SAMPLE_W-1:0] code_b;
	logic                over_a;
	logic                over_b;
	logic                strobe;
	modport src (output code_a, code_b, over_a, over_b, strobe);
	modport dst (input  code_a, code_b, over_a, over_b, strobe);
endinterface : sample_if

//--- hdl/sample_pipe.sv
// Module: fixed-latency delay line for both channels
`timescale 1ns/10ps
module sample_pipe
	import adc_ctrl_pkg::*;
#(
	parameter int DEPTH = PIPE_LATENCY
) (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	// Sample stroke
	input  wire logic       adv_i,
	// Streams
	sample_if.dst           in_if,
	sample_if.src           out_if
);
	localparam int W = 2 * SAMPLE_W + 2;

	logic [W-1:0] stage_ff [DEPTH];

	// One shift per sample clock, for data and flag alike
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_stage
			if (g == 0) begin : g_head
				always_ff @(posedge clk_i) begin
					if (srst_i) begin
						stage_ff[g] <= '0;
					end else if (adv_i) begin
						stage_ff[g] <= {in_if.over_b, in_if.over_a,
						                in_if.code_b, in_if.code_a};
					end
				end
			end else begin : g_tail
				always_ff @(posedge clk_i) begin
					if (srst_i) begin
						stage_ff[g] <= '0;
					end else if (adv_i) begin
						stage_ff[g] <= stage_ff[g-1];
					end
				end
			end
		end
	endgenerate

	assign out_if.code_a = stage_ff[DEPTH-1][SAMPLE_W-1:0];
	assign out_if.code_b = stage_ff[DEPTH-1][2*SAMPLE_W-1:SAMPLE_W];
	assign out_if.over_a = stage_ff[DEPTH-1][2*SAMPLE_W];
	assign out_if.over_b = stage_ff[DEPTH-1][2*SAMPLE_W+1];
	assign out_if.strobe = adv_i;

endmodule : sample_pipe
